// *** core/dbg_trace_pkg.sv ***
// Constants, types and register map for the trace readout block.
// Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
package dbg_trace_pkg;

   // ==========================================================
   // Bus
   localparam int          ADDR_W      = 8;
   localparam int          DATA_W      = 32;
   localparam int          STRB_W      = DATA_W / 8;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ==========================================================
   // Register indices; byte address is four times the index
   localparam logic [5:0]  IDX_CONTROL_ONE = 6'h20;
   localparam logic [5:0]  IDX_STATUS      = 6'h21;
   localparam logic [5:0]  IDX_TRACE_CTRL  = 6'h22;
   localparam logic [5:0]  IDX_WINDOW_HIGH = 6'h24;
   localparam logic [5:0]  IDX_WINDOW_LOW  = 6'h25;
   localparam logic [5:0]  IDX_LINE_COUNT  = 6'h26;
   localparam logic [5:0]  IDX_STATE_VIEW  = 6'h27;

   // ==========================================================
   // Field layout
   localparam int          REG_W        = 8;
   localparam int          ARM_BIT      = 7;
   localparam int          VIEW_LSB     = 0;
   localparam int          TSRC_BIT     = 6;
   localparam int          ALIGN_BIT    = 0;
   localparam int          FULL_BIT     = 7;
   localparam int          SSF_W        = 3;
   localparam int          SC_W         = 4;
   localparam int          COUNT_W      = 6;
   localparam int          LINE_W       = 20;
   localparam int          WINDOW_W     = 16;
   localparam int          LINES        = 64;
   localparam logic [1:0]  STRB_HALF    = 2'h3;

   // ==========================================================
   // Reset values
   localparam logic [SC_W-1:0]    SC_RST    = 4'h0;
   localparam logic [COUNT_W-1:0] COUNT_RST = 6'h00;

   // View select encoding at the shared address
   typedef enum logic [1:0] {
      VIEW_STATE1 = 2'h0,
      VIEW_STATE2 = 2'h1,
      VIEW_STATE3 = 2'h2,
      VIEW_MATCH  = 2'h3
   } view_t;

   // Trigger alignment
   typedef enum logic {
      ALIGN_END   = 1'b0,
      ALIGN_BEGIN = 1'b1
   } align_t;

   // One captured line from the trace source
   typedef struct packed {
      logic              valid;
      logic [LINE_W-1:0] line;
   } capture_t;

   // Next-state controls handed to the sequencer
   typedef struct packed {
      logic [SC_W-1:0] state3;
      logic [SC_W-1:0] state2;
      logic [SC_W-1:0] state1;
   } seq_ctrl_t;

endpackage

// *** core/debug_trace_readout.sv ***
// Trace buffer readout, valid-line count and shared state-control view.
// Assumes an AXI4-Lite master on aclk, capture and sequencer logic on
// aclk, and a secure level arriving from another domain.
`timescale 1ns/1ns

module debug_trace_readout
   import dbg_trace_pkg::*;
#(
   parameter int LINE_BITS  = LINE_W,
   parameter int COUNT_BITS = COUNT_W
) (
   // Clock, resets, enable
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic                       power_on_resetn,
   input  wire logic                       clk_en,
   // AXI4-Lite write address
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [dbg_trace_pkg::ADDR_W-1:0] awaddr,
   input  wire logic [2:0]                 awprot,
   // AXI4-Lite write data
   input  wire logic                       wvalid,
   output logic                            wready,
   input  wire logic [dbg_trace_pkg::DATA_W-1:0] wdata,
   input  wire logic [dbg_trace_pkg::STRB_W-1:0] wstrb,
   // AXI4-Lite write response
   output logic                            bvalid,
   input  wire logic                       bready,
   output logic [1:0]                      bresp,
   // AXI4-Lite read address
   input  wire logic                       arvalid,
   output logic                            arready,
   input  wire logic [dbg_trace_pkg::ADDR_W-1:0] araddr,
   input  wire logic [2:0]                 arprot,
   // AXI4-Lite read data
   output logic                            rvalid,
   input  wire logic                       rready,
   output logic [dbg_trace_pkg::DATA_W-1:0] rdata,
   output logic [1:0]                      rresp,
   // Trace source and sequencer side
   input  wire dbg_trace_pkg::capture_t    capture,
   input  wire logic [dbg_trace_pkg::SSF_W-1:0] sequencer_state,
   input  wire logic [dbg_trace_pkg::REG_W-1:0] match_flags,
   input  wire logic                       secure_pin,
   // Control handed out
   output logic                            armed,
   output logic                            trace_source_enable,
   output dbg_trace_pkg::align_t           trigger_alignment,
   output dbg_trace_pkg::seq_ctrl_t        seq_ctrl
);

   // ==========================================================
   // Helpers
   function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[7:2];
   endfunction

   function automatic logic is_aligned(input logic [ADDR_W-1:0] a);
      is_aligned = (a[1:0] == 2'h0);
   endfunction

   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = (idx == IDX_CONTROL_ONE) || (idx == IDX_STATUS) ||
                  (idx == IDX_TRACE_CTRL)  || (idx == IDX_WINDOW_HIGH) ||
                  (idx == IDX_WINDOW_LOW)  || (idx == IDX_LINE_COUNT) ||
                  (idx == IDX_STATE_VIEW);
   endfunction

   // ==========================================================
   // Declarations
   localparam logic [COUNT_BITS-1:0] COUNT_MAX = '1;

   logic                     rst;
   logic                     sec_meta;
   logic                     secured;
   logic                     aw_held;
   logic                     w_held;
   logic [ADDR_W-1:0]        aw_addr;
   logic [DATA_W-1:0]        w_data;
   logic [STRB_W-1:0]        w_strb;
   logic                     aw_fire;
   logic                     w_fire;
   logic                     ar_fire;
   logic                     do_write;
   logic                     next_aw_held;
   logic                     next_w_held;
   logic                     next_bvalid;
   logic [5:0]               wr_idx;
   logic                     wr_low;
   logic                     wr_half;
   logic [5:0]               rd_idx;
   view_t                    view;
   logic                     unlocked;
   logic [COUNT_BITS:0]      read_ptr;
   logic [COUNT_BITS-1:0]    count;
   logic                     full;
   logic [LINE_BITS-1:0]     mem [2**COUNT_BITS];
   logic                     capture_en;
   logic                     wrap;
   logic                     arm_set;
   logic                     arm_clr;
   logic                     window_ok;
   logic [LINE_BITS-1:0]     ptr_line;
   logic [WINDOW_W-1:0]      window_word;
   logic [REG_W-1:0]         view_word;
   logic [DATA_W-1:0]        next_rdata;

   assign rst = !aresetn || !power_on_resetn;

   // ==========================================================
   // Secure level synchroniser
   always_ff @(posedge aclk) begin
      if (rst) begin
         sec_meta <= 1'b1;
         secured  <= 1'b1;
      end else if (clk_en) begin
         sec_meta <= secure_pin;
         secured  <= sec_meta;
      end
   end

   // ==========================================================
   // Write channels: address and data in either order
   assign aw_fire  = awvalid && awready;
   assign w_fire   = wvalid && wready;
   assign do_write = aw_held && w_held && !bvalid;

   always_comb begin
      next_aw_held = (aw_held || aw_fire) && !do_write;
      next_w_held  = (w_held || w_fire) && !do_write;
      next_bvalid  = do_write || (bvalid && !bready);
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
      end else if (clk_en) begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         awready <= !next_aw_held && !next_bvalid;
         wready  <= !next_w_held && !next_bvalid;
         bvalid  <= next_bvalid;
         if (aw_fire) begin
            aw_addr <= awaddr;
         end
         if (w_fire) begin
            w_data <= wdata;
            w_strb <= wstrb;
         end
         if (do_write) begin
            bresp <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign wr_idx  = reg_index(aw_addr);
   assign wr_low  = do_write && is_aligned(aw_addr) && w_strb[0];
   assign wr_half = do_write && is_aligned(aw_addr) &&
                    (w_strb[1:0] == STRB_HALF);

   // ==========================================================
   // Arm bit and view select
   assign arm_set = wr_low && (wr_idx == IDX_CONTROL_ONE) &&
                    w_data[ARM_BIT];
   assign arm_clr = wr_low && (wr_idx == IDX_CONTROL_ONE) &&
                    !w_data[ARM_BIT];

   always_ff @(posedge aclk) begin
      if (rst) begin
         armed <= 1'b0;
      end else if (clk_en) begin
         if (arm_set) begin
            armed <= 1'b1;
         end else if (arm_clr) begin
            armed <= 1'b0;
         end else if (wrap && trigger_alignment == ALIGN_BEGIN) begin
            armed <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         view <= VIEW_STATE1;
      end else if (clk_en && wr_low && wr_idx == IDX_CONTROL_ONE) begin
         view <= view_t'(w_data[VIEW_LSB +: 2]);
      end
   end

   // ==========================================================
   // Trace control: source enable and alignment
   always_ff @(posedge aclk) begin
      if (rst) begin
         trace_source_enable <= 1'b0;
         trigger_alignment   <= ALIGN_END;
      end else if (clk_en) begin
         if (secured) begin
            // Secured parts never trace
            trace_source_enable <= 1'b0;
         end else if (wr_low && wr_idx == IDX_TRACE_CTRL && !armed) begin
            trace_source_enable <= w_data[TSRC_BIT];
         end
         if (wr_low && wr_idx == IDX_TRACE_CTRL && !armed) begin
            trigger_alignment <= align_t'(w_data[ALIGN_BIT]);
         end
      end
   end

   // ==========================================================
   // State control registers behind the shared address
   always_ff @(posedge aclk) begin
      if (rst) begin
         seq_ctrl <= '{SC_RST, SC_RST, SC_RST};
      end else if (clk_en && wr_low && wr_idx == IDX_STATE_VIEW &&
                   !armed) begin
         case (view)
            VIEW_STATE1: seq_ctrl.state1 <= w_data[SC_W-1:0];
            VIEW_STATE2: seq_ctrl.state2 <= w_data[SC_W-1:0];
            VIEW_STATE3: seq_ctrl.state3 <= w_data[SC_W-1:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Capture, count and full flag
   assign capture_en = capture.valid && armed && trace_source_enable;
   assign wrap       = capture_en && (count == COUNT_MAX);

   // Only power-on reset clears these; they report lines kept across
   // an ordinary system reset. A write that sets the arm bit also clears them.
   always_ff @(posedge aclk) begin
      if (!power_on_resetn) begin
         count <= COUNT_RST;
         full  <= 1'b0;
      end else if (clk_en) begin
         if (arm_set) begin
            count <= COUNT_RST;
         end else if (capture_en) begin
            count <= count + 1'b1;
         end
         // Wrap wins over a clear in the same cycle
         full <= wrap || (full && !arm_set);
      end
   end

   // No reset: contents survive every reset
   always_ff @(posedge aclk) begin
      if (clk_en && capture_en) begin
         mem[count] <= capture.line;
      end
   end

   // ==========================================================
   // Lock and read pointer
   assign rd_idx    = reg_index(araddr);
   assign window_ok = unlocked && !secured && !armed &&
                      trace_source_enable;
   assign ar_fire   = arvalid && arready;

   always_ff @(posedge aclk) begin
      if (rst) begin
         unlocked <= 1'b0;
         read_ptr <= '0;
      end else if (clk_en) begin
         if (arm_set) begin
            unlocked <= 1'b0;
         end else if (wr_half && wr_idx == IDX_WINDOW_HIGH && !armed) begin
            unlocked <= 1'b1;
            // Oldest line is the next write slot once wrapped
            read_ptr <= {full ? count : COUNT_RST, 1'b0};
         end else if (ar_fire && rd_idx == IDX_WINDOW_HIGH &&
                      is_aligned(araddr) && window_ok) begin
            read_ptr <= read_ptr + 1'b1;
         end
      end
   end

   // ==========================================================
   // Read data
   assign ptr_line = mem[read_ptr[COUNT_BITS:1]];

   always_comb begin
      // High portion first, then the low sixteen bits
      if (read_ptr[0]) begin
         window_word = ptr_line[WINDOW_W-1:0];
      end else begin
         window_word = WINDOW_W'(ptr_line[LINE_BITS-1:WINDOW_W]);
      end
      case (view)
         VIEW_STATE1: view_word = REG_W'(seq_ctrl.state1);
         VIEW_STATE2: view_word = REG_W'(seq_ctrl.state2);
         VIEW_STATE3: view_word = REG_W'(seq_ctrl.state3);
         VIEW_MATCH:  view_word = match_flags;
         default:     view_word = '0;
      endcase
      next_rdata = '0;
      if (is_aligned(araddr)) begin
         case (rd_idx)
            IDX_CONTROL_ONE: begin
               next_rdata[ARM_BIT]       = armed;
               next_rdata[VIEW_LSB +: 2] = view;
            end
            IDX_STATUS: begin
               next_rdata[FULL_BIT]  = full;
               next_rdata[SSF_W-1:0] = sequencer_state;
            end
            IDX_TRACE_CTRL: begin
               next_rdata[TSRC_BIT]  = trace_source_enable;
               next_rdata[ALIGN_BIT] = trigger_alignment;
            end
            IDX_WINDOW_HIGH: begin
               if (window_ok) begin
                  next_rdata[WINDOW_W-1:0] = window_word;
               end
            end
            IDX_LINE_COUNT: begin
               next_rdata[FULL_BIT]     = full;
               next_rdata[COUNT_W-1:0]  = count;
            end
            IDX_STATE_VIEW: next_rdata[REG_W-1:0] = view_word;
            default: next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (ar_fire) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= next_rdata;
            rresp   <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end else if (!rvalid) begin
            arready <= 1'b1;
         end
      end
   end

endmodule

// *** dv/debug_trace_props.sv ***
// Concurrent checks on the trace readout block, bound to its top.
// Assumes the package is compiled first and a single aclk domain.
`timescale 1ns/1ns

module debug_trace_props
   import dbg_trace_pkg::*;
#(
   parameter int LINE_BITS  = LINE_W,
   parameter int COUNT_BITS = COUNT_W
) (
   // Clock and resets
   input wire logic                    aclk,
   input wire logic                    aresetn,
   input wire logic                    power_on_resetn,
   // Bus signals watched
   input wire logic                    bvalid,
   input wire logic                    arvalid,
   input wire logic                    arready,
   input wire logic [ADDR_W-1:0]       araddr,
   input wire logic                    rvalid,
   input wire logic [DATA_W-1:0]       rdata,
   // Secure input and control outputs
   input wire logic                    secure_pin,
   input wire logic                    armed,
   input wire logic                    trace_source_enable,
   input wire dbg_trace_pkg::align_t   trigger_alignment,
   input wire dbg_trace_pkg::seq_ctrl_t seq_ctrl
);
   // ==========================================================
   // Common context
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn || !power_on_resetn);

   wire ar_take = arvalid && arready;
   wire ar_win  = ar_take && araddr == 8'h90;

   // ==========================================================
   // Assertions
   gated_read_a: assert property (ar_win && (armed || !trace_source_enable)
      |=> rdata == 32'h0) else $error("gated window read not zero");
   odd_read_a: assert property (ar_take && araddr[1:0] != 2'h0
      |=> rvalid && rdata == 32'h0) else $error("misaligned read not zero");
   low_byte_a: assert property (ar_take && araddr == 8'h94
      |=> rdata == 32'h0) else $error("low byte read not zero");
   arm_by_write_a: assert property ($rose(armed) |-> $rose(bvalid))
      else $error("armed rose without a write");
   align_write_a: assert property ($changed(trigger_alignment)
      |-> $rose(bvalid) && !$past(armed)) else $error("alignment moved");
   ctrl_write_a: assert property ($changed(seq_ctrl)
      |-> $rose(bvalid) && !$past(armed)) else $error("state ctrl moved");
   begin_stop_a: assert property ($fell(armed) && !$rose(bvalid)
      |-> trigger_alignment == ALIGN_BEGIN) else $error("stray disarm");
   secure_a: assert property (secure_pin [*4] |-> !trace_source_enable)
      else $error("trace source enabled while secured");

   cover property (ar_win && trace_source_enable && !armed);
   cover property ($fell(armed) && !$rose(bvalid));
   cover property ($changed(seq_ctrl));
endmodule

bind debug_trace_readout debug_trace_props #(
   .LINE_BITS (LINE_BITS),
   .COUNT_BITS(COUNT_BITS)
) i_debug_trace_props (
   .aclk, .aresetn, .power_on_resetn, .bvalid, .arvalid, .arready, .araddr,
   .rvalid, .rdata, .secure_pin, .armed, .trace_source_enable,
   .trigger_alignment, .seq_ctrl
);

// *** dv/tb_debug_trace_readout.sv ***
// Self-checking bench for the trace readout block over AXI4-Lite.
// Assumes the package and the checker are compiled before this file.
`timescale 1ns/1ns

module tb_debug_trace_readout;
   import dbg_trace_pkg::*;

   logic               aclk = 1'b0;
   logic               aresetn = 1'b0;
   logic               power_on_resetn = 1'b0;
   logic               awvalid = 1'b0;
   logic               wvalid = 1'b0;
   logic               bready = 1'b0;
   logic               arvalid = 1'b0;
   logic               rready = 1'b0;
   logic               secure_pin = 1'b0;
   logic [ADDR_W-1:0]  awaddr = '0;
   logic [ADDR_W-1:0]  araddr = '0;
   logic [DATA_W-1:0]  wdata = '0;
   logic [STRB_W-1:0]  wstrb = '0;
   capture_t           capture = '0;
   logic               awready, wready, bvalid, arready, rvalid;
   logic               clk_en = 1'b1;
   logic [1:0]         bresp, rresp, rd_resp, wr_resp;
   logic [DATA_W-1:0]  rdata, rd_data;
   logic               armed, trace_source_enable;
   align_t             trigger_alignment;
   seq_ctrl_t          seq_ctrl;
   int                 error_cnt = 0;
   int                 check_count = 0;

   debug_trace_readout i_debug_trace_readout (
      .aclk, .aresetn, .power_on_resetn, .clk_en,
      .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
      .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .capture,
      .sequencer_state(3'h5), .match_flags(8'h5A), .secure_pin, .armed,
      .trace_source_enable, .trigger_alignment, .seq_ctrl
   );

   always #25 aclk = ~aclk;

   // ==========================================================
   // Shared tasks
   function automatic logic [LINE_W-1:0] line_of(input int i);
      return {4'(i + 3), 16'(32'hA500 + i)};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'h1);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr  <= a;
      wvalid  <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready && !aw_done) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (wready && !w_done) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end while (!bvalid);
      wr_resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      logic ar_done;
      ar_done = 1'b0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr  <= a;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready && !ar_done) begin
            arvalid <= 1'b0;
            ar_done = 1'b1;
         end
      end while (!rvalid);
      rd_data = rdata;
      rd_resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_data, exp);
   endtask

   task automatic cap(input int n, input int first);
      for (int i = first; i < first + n; i++) begin
         @(posedge aclk);
         capture <= {1'b1, line_of(i)};
      end
      @(posedge aclk);
      capture <= '0;
   endtask

   // Extra edges let the secure synchroniser settle
   task automatic do_reset(input logic por);
      @(posedge aclk);
      aresetn <= 1'b0;
      power_on_resetn <= !por;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      power_on_resetn <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_idle();
      rchk(8'h98, 32'h0);
      rchk(8'h90, 32'h0);
      rd(8'h84);
      chk(rd_data & 32'h87, 32'h05);
      rd(8'hFC);
      chk(32'(rd_resp), 32'(RESP_SLVERR));
      wr(8'hFC, 32'h0);
      chk(32'(wr_resp), 32'(RESP_SLVERR));
   endtask

   task automatic t_read();
      wr(8'h88, 32'h40);
      wr(8'h80, 32'h80);
      cap(3, 0);
      rchk(8'h90, 32'h0);
      rchk(8'h98, 32'h3);
      wr(8'h98, 32'h3F);
      rchk(8'h98, 32'h3);
      wr(8'h80, 32'h0);
      rchk(8'h90, 32'h0);
      wr(8'h90, 32'hFFFF, 4'h3);
      rchk(8'h91, 32'h0);
      rchk(8'h94, 32'h0);
      for (int i = 0; i < 3; i++) begin
         rchk(8'h90, 32'(line_of(i) >> 16));
         rchk(8'h90, 32'(line_of(i) & 20'hFFFF));
      end
      rchk(8'h98, 32'h3);
      wr(8'h90, 32'hFFFF, 4'h3);
      rchk(8'h90, 32'(line_of(0) >> 16));
      // Arming must relock a buffer that was unlocked
      wr(8'h80, 32'h80);
      wr(8'h80, 32'h0);
      rchk(8'h90, 32'h0);
   endtask

   task automatic t_full();
      wr(8'h80, 32'h80);
      rchk(8'h98, 32'h0);
      cap(64, 0);
      rchk(8'h98, 32'h80);
      rd(8'h84);
      chk(rd_data & 32'h87, 32'h85);
      cap(1, 64);
      rchk(8'h98, 32'h81);
      do_reset(1'b0);
      rchk(8'h98, 32'h81);
      wr(8'h88, 32'h40);
      wr(8'h90, 32'hFFFF, 4'h3);
      rchk(8'h90, 32'(line_of(1) >> 16));
      rchk(8'h90, 32'(line_of(1) & 20'hFFFF));
      wr(8'h80, 32'h80);
      rchk(8'h98, 32'h0);
      cap(2, 0);
      // Captures offered with the enable low must be ignored
      clk_en <= 1'b0;
      cap(2, 2);
      clk_en <= 1'b1;
      rchk(8'h98, 32'h2);
      do_reset(1'b1);
      rchk(8'h98, 32'h0);
   endtask

   task automatic t_begin();
      wr(8'h88, 32'h41);
      chk(32'(trigger_alignment), 32'(ALIGN_BEGIN));
      wr(8'h80, 32'h80);
      cap(64, 0);
      // Disarm lands on the edge that takes the last line
      @(posedge aclk);
      chk(32'(armed), 32'h0);
      rchk(8'h98, 32'h80);
      wr(8'h88, 32'h40);
   endtask

   task automatic t_view();
      for (int v = 0; v < 3; v++) begin
         wr(8'h80, 32'(v));
         wr(8'h9C, 32'(v + 9));
         rchk(8'h9C, 32'(v + 9));
      end
      chk(32'(seq_ctrl), 32'hBA9);
      wr(8'h80, 32'h3);
      rchk(8'h9C, 32'h5A);
      wr(8'h9C, 32'h7);
      wr(8'h80, 32'h80);
      wr(8'h9C, 32'h3);
      wr(8'h80, 32'h0);
      chk(32'(seq_ctrl), 32'hBA9);
   endtask

   task automatic t_secure();
      wr(8'h90, 32'hFFFF, 4'h3);
      secure_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(32'(trace_source_enable), 32'h0);
      wr(8'h88, 32'h40);
      chk(32'(trace_source_enable), 32'h0);
      rchk(8'h90, 32'h0);
      secure_pin <= 1'b0;
   endtask

   // ==========================================================
   // Run control
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      do_reset(1'b1);
      t_idle();
      t_read();
      t_full();
      t_begin();
      t_view();
      t_secure();
      report_and_stop();
   end

   // The full run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      report_and_stop();
   end
endmodule
